// *** rtl/pdmc_power_down_mode_control.v ***
// Purpose: power-down mode control registers and mode sequencer
// Assumes: one clock; states counted on clk; sleep is a one-cycle pulse
// Assumes: watchTimerSel tells standby from watch when leaving active
// Notes: peripheral gating outputs follow the current low-power mode
// Notes: one settling state is one clk; wait counts are exact
// Notes: extIrqIgnore lags powerMode by one cycle
// Notes: direct transfer bit is stored and read back only
//
// What this block does
// - standby bit 0: sleep goes active to sleep, subactive to subsleep
// - standby bit 1: sleep goes active to standby/watch, subactive to watch
// - three-bit wait field maps to 8192..131072, 2, 8, 16 states; resets 000
// - wake from standby, or from watch to active, holds CPU for selected wait states
// - low-speed flag picks system clock or subclock after watch mode
// - control one bit 2 reads 1 and ignores writes
// - divider field picks osc/16, /32, /64, /128; resets 11
// - control one at FFF0, reset 07, field layout as listed
// - control two at FFF1, reset F0, bits 7:5 read 1 unwritable
// - control two holds noise select, direct transfer, medium, sub clock
// - in retained modes external interrupt requests are ignored
// - in marked mode async counter counts but its interrupt is blocked
// - timekeeping timer runs only with time-base; ports go high-Z
// - timer on external or watch/4 clock runs, else halts
// - watchdog runs only on watch/32 clock, else halts
// - medium-speed bit picks active high or medium after wakeup
// - sub clock field picks watch/8,/4,/2; frozen in subactive mode
// - noise select picks osc/16 or osc/4 watch clock sampling
`timescale 1ns/10ps
`include "pdmc_regs.vh"

module pdmc_power_down_mode_control #(
    parameter WAIT_W = 18
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [15:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    // cpu events
    input wire sleepExec,
    input wire wakeIrq,
    input wire watchTimerSel,
    // mode and clock selection
    output reg [2:0] powerMode,
    output reg cpuRun,
    output reg cpuOnSubclock,
    output reg [1:0] mediumDivider,
    output reg [1:0] subClockSel,
    output reg noiseSampleFast,
    // peripheral gating
    output reg extIrqIgnore,
    output reg asyncIrqBlock,
    output reg portsHighZ,
    output reg timerWatchOnly
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] ctrlOne_r;
reg [7:0] ctrlTwo_r;
reg [2:0] mode_r;
reg [2:0] mode_nxt;
reg [2:0] wakeMode_r;
reg [2:0] wakeMode_nxt;
reg [WAIT_W-1:0] waitCnt_r;
reg [WAIT_W-1:0] waitCnt_nxt;
reg [WAIT_W-1:0] waitLen;
wire wrOne;
wire wrTwo;
wire inSub;
wire lowPower;
wire standbyBit;
wire [2:0] waitSel;
wire lowSpeedFlag;
wire [1:0] mediumDiv;
wire noiseSel;
wire [1:0] subClk;
wire modeRuns;
wire modeOnSub;
wire modeStandby;
wire modeWatchOnly;
reg [7:0] regRdata_nxt;

assign wrOne = regWr && (regAddr == `PDMC_ADDR_CTRL_ONE);
assign wrTwo = regWr && (regAddr == `PDMC_ADDR_CTRL_TWO);
assign inSub = (mode_r == `PDMC_MODE_SUBACT);
assign lowPower = (mode_r == `PDMC_MODE_STANDBY) ||
    (mode_r == `PDMC_MODE_WATCH) || (mode_r == `PDMC_MODE_WAKEWAIT);

// ----------------------------------------
// control field views
// ----------------------------------------
// named slices of the two control registers
assign standbyBit = ctrlOne_r[`PDMC_ONE_STBY];
assign waitSel = ctrlOne_r[`PDMC_ONE_WAIT_HI:`PDMC_ONE_WAIT_LO];
assign lowSpeedFlag = ctrlOne_r[`PDMC_ONE_LSPD];
assign mediumDiv = ctrlOne_r[`PDMC_ONE_MDIV_HI:`PDMC_ONE_MDIV_LO];
assign noiseSel = ctrlTwo_r[`PDMC_TWO_NSEL];
assign subClk = ctrlTwo_r[`PDMC_TWO_SCLK_HI:`PDMC_TWO_SCLK_LO];

// ----------------------------------------
// control register writes
// ----------------------------------------
// reserved bits forced high, writable bits masked; the divider field
// takes effect at once in any mode, so software keeps its writes to the
// high-speed and subactive modes
always @(posedge clk) begin
    if (rst) begin
        ctrlOne_r <= `PDMC_RST_CTRL_ONE;
        ctrlTwo_r <= `PDMC_RST_CTRL_TWO;
    end else begin
        if (wrOne) begin
            ctrlOne_r <= (regWdata & `PDMC_ONE_WMASK) |
                `PDMC_ONE_FIXED;
        end
        if (wrTwo) begin
            ctrlTwo_r[7:5] <= `PDMC_TWO_RSVD_ONES;
            ctrlTwo_r[`PDMC_TWO_NSEL:`PDMC_TWO_MSPD] <=
                regWdata[`PDMC_TWO_NSEL:`PDMC_TWO_MSPD];
            // the cpu runs on this clock in subactive, so it is frozen there
            if (!inSub) begin
                ctrlTwo_r[`PDMC_TWO_SCLK_HI:`PDMC_TWO_SCLK_LO] <=
                    regWdata[`PDMC_TWO_SCLK_HI:`PDMC_TWO_SCLK_LO];
            end
        end
    end
end

// read data next value, unmapped reads and idle cycles give zero
always @* begin
    regRdata_nxt = 8'h00;
    if (regRd) begin
        case (regAddr)
            `PDMC_ADDR_CTRL_ONE: begin
                regRdata_nxt = ctrlOne_r | `PDMC_ONE_FIXED;
            end
            `PDMC_ADDR_CTRL_TWO: begin
                regRdata_nxt = ctrlTwo_r | `PDMC_TWO_FIXED;
            end
            default: regRdata_nxt = 8'h00;
        endcase
    end
end

// read data stands for the one cycle after the strobe
always @(posedge clk) begin
    if (rst) begin
        regRdata <= 8'h00;
    end else begin
        regRdata <= regRdata_nxt;
    end
end

// ----------------------------------------
// wait length decode
// ----------------------------------------
// settling wait in states from the wait field
// counts are exact clk states; setting 5 is the external clock setting
always @* begin
    case (waitSel)
        3'h0: waitLen = `PDMC_WAIT_0;
        3'h1: waitLen = `PDMC_WAIT_1;
        3'h2: waitLen = `PDMC_WAIT_2;
        3'h3: waitLen = `PDMC_WAIT_3;
        3'h4: waitLen = `PDMC_WAIT_4;
        3'h5: waitLen = `PDMC_WAIT_5;
        3'h6: waitLen = `PDMC_WAIT_6;
        default: waitLen = `PDMC_WAIT_7;
    endcase
end

// ----------------------------------------
// mode sequencer
// ----------------------------------------
// bits sampled at the sleep pulse pick the target mode
// the bits are read in the very cycle of the sleep pulse, so a write in
// that same cycle is too late for that sleep
always @* begin
    mode_nxt = mode_r;
    wakeMode_nxt = wakeMode_r;
    waitCnt_nxt = waitCnt_r;
    case (mode_r)
        `PDMC_MODE_ACT_HS, `PDMC_MODE_ACT_MS: begin
            if (sleepExec) begin
                if (!standbyBit) begin
                    mode_nxt = `PDMC_MODE_SLEEP;
                end else if (watchTimerSel) begin
                    mode_nxt = `PDMC_MODE_WATCH;
                end else begin
                    mode_nxt = `PDMC_MODE_STANDBY;
                end
            end
        end
        `PDMC_MODE_SUBACT: begin
            if (sleepExec) begin
                mode_nxt = standbyBit ?
                    `PDMC_MODE_WATCH : `PDMC_MODE_SUBSLEEP;
            end
        end
        `PDMC_MODE_SLEEP: begin
            if (wakeIrq) begin
                mode_nxt = ctrlTwo_r[`PDMC_TWO_MSPD] ?
                    `PDMC_MODE_ACT_MS : `PDMC_MODE_ACT_HS;
            end
        end
        `PDMC_MODE_SUBSLEEP: begin
            if (wakeIrq) begin
                mode_nxt = `PDMC_MODE_SUBACT;
            end
        end
        `PDMC_MODE_STANDBY, `PDMC_MODE_WATCH: begin
            if (wakeIrq) begin
                if (mode_r == `PDMC_MODE_WATCH &&
                    lowSpeedFlag) begin
                    mode_nxt = `PDMC_MODE_SUBACT;
                end else begin
                    mode_nxt = `PDMC_MODE_WAKEWAIT;
                    waitCnt_nxt = waitLen - 1'b1;
                    wakeMode_nxt = ctrlTwo_r[`PDMC_TWO_MSPD] ?
                        `PDMC_MODE_ACT_MS : `PDMC_MODE_ACT_HS;
                end
            end
        end
        // loaded with the length less one: the cpu stays stopped for
        // exactly the selected number of states
        `PDMC_MODE_WAKEWAIT: begin
            if (waitCnt_r == {WAIT_W{1'b0}}) begin
                mode_nxt = wakeMode_r;
            end else begin
                waitCnt_nxt = waitCnt_r - 1'b1;
            end
        end
        default: mode_nxt = `PDMC_MODE_ACT_HS;
    endcase
end

// sequencer state
always @(posedge clk) begin
    if (rst) begin
        mode_r <= `PDMC_MODE_ACT_HS;
        wakeMode_r <= `PDMC_MODE_ACT_HS;
        waitCnt_r <= {WAIT_W{1'b0}};
    end else begin
        mode_r <= mode_nxt;
        wakeMode_r <= wakeMode_nxt;
        waitCnt_r <= waitCnt_nxt;
    end
end

// ----------------------------------------
// mode classes
// ----------------------------------------
// the cpu clock runs only in the active and subactive modes; a wake
// wait keeps it stopped until the settling count has run out
assign modeRuns = (mode_nxt == `PDMC_MODE_ACT_HS) ||
    (mode_nxt == `PDMC_MODE_ACT_MS) ||
    (mode_nxt == `PDMC_MODE_SUBACT);
// modes clocked from the subclock
assign modeOnSub = (mode_nxt == `PDMC_MODE_SUBACT) ||
    (mode_nxt == `PDMC_MODE_SUBSLEEP);
// clock generator stopped: ports float, async counter interrupt held off
assign modeStandby = (mode_nxt == `PDMC_MODE_STANDBY);
// outside active and sleep only watch-clock timers keep counting
assign modeWatchOnly = (mode_nxt != `PDMC_MODE_ACT_HS) &&
    (mode_nxt != `PDMC_MODE_ACT_MS) &&
    (mode_nxt != `PDMC_MODE_SLEEP);

// ----------------------------------------
// registered outputs
// ----------------------------------------
// cpu clock select and peripheral gating follow next mode; field selects copy the control bits; extIrqIgnore follows current mode
always @(posedge clk) begin
    if (rst) begin
        powerMode <= `PDMC_MODE_ACT_HS;
        cpuRun <= 1'b1;
        cpuOnSubclock <= 1'b0;
        mediumDivider <= 2'h3;
        subClockSel <= 2'h0;
        noiseSampleFast <= 1'b1;
        extIrqIgnore <= 1'b0;
        asyncIrqBlock <= 1'b0;
        portsHighZ <= 1'b0;
        timerWatchOnly <= 1'b0;
    end else begin
        powerMode <= mode_nxt;
        cpuRun <= modeRuns;
        cpuOnSubclock <= modeOnSub;
        mediumDivider <= mediumDiv;
        subClockSel <= subClk;
        noiseSampleFast <= noiseSel;
        extIrqIgnore <= lowPower;
        asyncIrqBlock <= modeStandby;
        portsHighZ <= modeStandby;
        timerWatchOnly <= modeWatchOnly;
    end
end

endmodule // pdmc_power_down_mode_control

// *** rtl/pdmc_regs.vh ***
// Purpose: constants for the power-down mode control block
// Assumes: byte-wide registers on a plain address/strobe port
// Notes: offsets are the printed register addresses
`ifndef PDMC_REGS_VH
`define PDMC_REGS_VH
`define PDMC_ADDR_CTRL_ONE 16'hFFF0
`define PDMC_ADDR_CTRL_TWO 16'hFFF1
`define PDMC_RST_CTRL_ONE 8'h07
`define PDMC_RST_CTRL_TWO 8'hF0
`define PDMC_ONE_STBY 7
`define PDMC_ONE_WAIT_HI 6
`define PDMC_ONE_WAIT_LO 4
`define PDMC_ONE_LSPD 3
`define PDMC_ONE_RSVD 2
`define PDMC_ONE_MDIV_HI 1
`define PDMC_ONE_MDIV_LO 0
`define PDMC_ONE_WMASK 8'hFB
`define PDMC_ONE_FIXED 8'h04
`define PDMC_TWO_WMASK 8'h1F
`define PDMC_TWO_FIXED 8'hE0
`define PDMC_TWO_RSVD_ONES 3'h7
`define PDMC_TWO_NSEL 4
`define PDMC_TWO_DIRECT 3
`define PDMC_TWO_MSPD 2
`define PDMC_TWO_SCLK_HI 1
`define PDMC_TWO_SCLK_LO 0
`define PDMC_WAIT_0 18'h02000
`define PDMC_WAIT_1 18'h04000
`define PDMC_WAIT_2 18'h08000
`define PDMC_WAIT_3 18'h10000
`define PDMC_WAIT_4 18'h20000
`define PDMC_WAIT_5 18'h00002
`define PDMC_WAIT_6 18'h00008
`define PDMC_WAIT_7 18'h00010
`define PDMC_MODE_ACT_HS 3'h0
`define PDMC_MODE_ACT_MS 3'h1
`define PDMC_MODE_SUBACT 3'h2
`define PDMC_MODE_SLEEP 3'h3
`define PDMC_MODE_SUBSLEEP 3'h4
`define PDMC_MODE_STANDBY 3'h5
`define PDMC_MODE_WATCH 3'h6
`define PDMC_MODE_WAKEWAIT 3'h7
`endif

// *** tb/pdmc_power_down_mode_control_properties.sv ***
// Purpose: port checks for the power-down mode control block
// Assumes: one clock, sync active-high reset
// Notes: bound to the design top below
`timescale 1ns/10ps
module pdmc_power_down_mode_control_properties (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [15:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdata,
    // mode side
    input wire wakeIrq,
    input wire [2:0] powerMode,
    input wire [1:0] subClockSel,
    input wire extIrqIgnore,
    input wire asyncIrqBlock,
    input wire portsHighZ
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    rsv_one_a: assert property (
        regRd && regAddr == 16'hFFF0 |=> regRdata[2])
        else $error("control one bit 2 low");
    rsv_two_a: assert property (
        regRd && regAddr == 16'hFFF1 |=> regRdata[7:5] == 3'h7)
        else $error("control two top bits low");
    rd_idle_a: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data outside read slot");
    wr_rd_a: assert property (
        regWr && regAddr == 16'hFFF0 ##1 regRd && regAddr == 16'hFFF0
        |=> regRdata == ($past(regWdata, 2) | 8'h04))
        else $error("control one readback wrong");
    sub_frozen_a: assert property (
        powerMode == 3'h2 && regWr && regAddr == 16'hFFF1
        |=> $stable(subClockSel) [*2])
        else $error("sub clock changed in subactive");
    wake_wait_a: assert property (
        powerMode == 3'h5 && wakeIrq |=> powerMode == 3'h7 [*2])
        else $error("no wait after standby wake");
    port_hiz_a: assert property (
        powerMode == 3'h5 |-> portsHighZ && asyncIrqBlock)
        else $error("standby gating missing");
    irq_ign_a: assert property (powerMode == 3'h6 |=> extIrqIgnore)
        else $error("interrupts not ignored");
    cover property (powerMode == 3'h7 ##1 powerMode == 3'h0);
    cover property (powerMode == 3'h4);
    cover property (powerMode == 3'h2 && regWr);
endmodule // pdmc_power_down_mode_control_properties

bind pdmc_power_down_mode_control pdmc_power_down_mode_control_properties
    pdmc_power_down_mode_control_properties_i (.clk, .rst, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .wakeIrq, .powerMode,
    .subClockSel, .extIrqIgnore, .asyncIrqBlock, .portsHighZ);

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the power-down mode control block
// Assumes: strobes driven at the rising edge, one state is one clk
// Notes: model holds both registers and the current mode
`timescale 1ns/10ps
module tb_top;
    reg clk, rst = 1, regWr = 0, regRd = 0, sleepExec = 0, wakeIrq = 0;
    reg watchTimerSel = 0;
    reg [15:0] regAddr = 16'h0000;
    reg [7:0] regWdata = 8'h00, m1 = 8'h07, m2 = 8'hF0;
    wire [7:0] regRdata;
    wire [2:0] powerMode;
    wire [1:0] mediumDivider, subClockSel;
    wire cpuRun, cpuOnSubclock, noiseSampleFast, extIrqIgnore;
    wire asyncIrqBlock, portsHighZ, timerWatchOnly;
    integer n_fail = 0, n_tests = 0, md = 0, i, w, wt, ms, s;
    pdmc_power_down_mode_control pdmc_power_down_mode_control_i (.clk, .rst,
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .sleepExec, .wakeIrq,
        .watchTimerSel, .powerMode, .cpuRun, .cpuOnSubclock, .mediumDivider,
        .subClockSel, .noiseSampleFast, .extIrqIgnore, .asyncIrqBlock,
        .portsHighZ, .timerWatchOnly);
    // compare and count
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: %h, expected %h", $time, g, e);
            end
        end
    endtask
    // mode outputs against the mode model
    task chkMode(input integer e);
        begin
            chk(powerMode, e);
            chk({cpuRun, cpuOnSubclock, timerWatchOnly, portsHighZ},
                {e < 3, e == 2 || e == 4, e > 3 || e == 2, e == 5});
            chk(asyncIrqBlock, e == 5);
        end
    endtask
    // one write cycle, model follows
    task wr(input [15:0] a, input [7:0] v);
        begin
            @(posedge clk);
            regAddr <= a;
            regWdata <= v;
            regWr <= 1'b1;
            regRd <= 1'b0;
            if (a == 16'hFFF0) m1 = v | 8'h04;
            if (a == 16'hFFF1) m2 = {3'h7, v[4:2], md == 2 ? m2[1:0] : v[1:0]};
        end
    endtask
    // one read cycle, data checked in the next
    task rd(input [15:0] a, input [7:0] e);
        begin
            @(posedge clk);
            regAddr <= a;
            regRd <= 1'b1;
            regWr <= 1'b0;
            @(posedge clk);
            regRd <= 1'b0;
            @(negedge clk);
            chk(regRdata, e);
        end
    endtask
    // sleep pulse and resulting mode
    task slp(input integer e);
        begin
            @(posedge clk);
            regWr <= 1'b0;
            sleepExec <= 1'b1;
            @(posedge clk);
            sleepExec <= 1'b0;
            @(negedge clk);
            chkMode(e);
            md = e;
        end
    endtask
    // wake pulse, count wait states, check landing mode
    task wk(input integer n, input integer e);
        integer c;
        begin
            @(posedge clk);
            wakeIrq <= 1'b1;
            @(posedge clk);
            wakeIrq <= 1'b0;
            c = 0;
            @(negedge clk);
            if (n > 0) chk({cpuRun, powerMode}, 4'h7);
            while (c < n + 8 && powerMode === 3'h7) begin
                c = c + 1;
                @(negedge clk);
            end
            chk(c, n);
            chkMode(e);
            md = e;
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        // longest waits are 8192 and 16384 states plus register traffic
        #(50 * 60000);
        n_fail = n_fail + 1;
        test_done;
    end
    // main sequence
    initial begin
        s = $urandom(73);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(16'hFFF0, 8'h07);
        rd(16'hFFF1, 8'hF0);
        chk({mediumDivider, noiseSampleFast, powerMode}, 6'h38);
        chkMode(0);
        $display("reset test done");
        for (i = 0; i < 12; i = i + 1) begin
            wr(16'hFFF0 + i % 3, $urandom);
            rd(16'hFFF0, m1);
            rd(16'hFFF1, m2);
        end
        chk({mediumDivider, subClockSel, noiseSampleFast},
            {m1[1:0], m2[1:0], m2[4]});
        $display("register test done");
        // wait setting 5 only where the bench stands for an external clock
        for (i = 0; i < 5; i = i + 1) begin
            w = i < 2 ? i : i + 3;
            wt = w < 2 ? 8192 << w : w == 5 ? 2 : 8 << (w - 6);
            ms = $urandom % 2;
            @(posedge clk) watchTimerSel <= i[0];
            wr(16'hFFF0, {1'b0, w[2:0], 4'h0});
            wr(16'hFFF1, {5'h00, ms[0], 2'h0});
            slp(3);
            wk(0, ms);
            wr(16'hFFF0, {1'b1, w[2:0], 4'h0});
            slp(i[0] ? 6 : 5);
            wk(wt, ms);
        end
        $display("wait test done");
        @(posedge clk) watchTimerSel <= 1'b1;
        wr(16'hFFF0, 8'hE8);
        slp(6);
        wk(0, 2);
        chk(cpuOnSubclock, 1);
        wr(16'hFFF1, 8'h03);
        rd(16'hFFF1, m2);
        wr(16'hFFF0, 8'h68);
        slp(4);
        wk(0, 2);
        wr(16'hFFF0, 8'hE0);
        slp(6);
        wk(8, 0);
        $display("subactive test done");
        test_done;
    end
endmodule // tb_top
